//--- rem_pkg.sv
// Constants and types shared by the remote encoder design.
// Functional notes
// - A high trigger activates the encoder and samples all address and data inputs.
// - One cycle is three words, repeated continuously while the trigger stays high.
// - After the trigger falls, the running cycle completes untruncated, then sending stops.
// - A word is ten address bits then eight data bits, lowest first.
// - Every new cycle begun with the trigger high re-samples the inputs.
// - A data change with trigger high is sent within 150 ms.
// - The serial packet drives the modulator directly as its bit stream.
// - Data strap high: data high sends one, data low sends zero.
// - Data strap low: data high sends one, data low sends open.
// - Address straps 00 and 11 plain, 01 low is open, 10 high is open.
// - Unconnected straps: data low, address low strap low, address high strap high.
// - Unconnected address inputs read high, unconnected data inputs read low.
// - Strap settings must be identical on encoder and decoder.
package rem_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int WORD_BITS = 18;
  localparam int WORDS_PER_CYCLE = 3;
  localparam int GAP_SYMS = 4;
  localparam int SYM_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_HZ = 10_000_000;
  localparam int LAG_MAX_MS = 150;
  localparam int LAG_MAX_CYC = LAG_MAX_MS * (CLK_HZ / 1000);
  localparam int SYMS_PER_CYCLE = WORDS_PER_CYCLE * (WORD_BITS + GAP_SYMS);
  // Worst lag is the rest of one cycle plus the whole next one, four chips a symbol.
  localparam int CHIP_MAX = LAG_MAX_CYC / (2 * SYMS_PER_CYCLE * 4);
  localparam logic [15:0] CHIP_MAX_16 = 16'(CHIP_MAX);
  localparam logic [15:0] CHIP_RST = 16'h03e8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SAMPLE = 8'h08;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TRIG_BIT = 1;
  localparam int ST_WORD_LSB = 2;
  localparam int ST_CNT_LSB = 8;
  localparam int SMP_DATA_LSB = 10;
  localparam int SMP_STRAP_LSB = 18;
  localparam logic [SYM_W-1:0] SYM_ZERO = 2'h0;
  localparam logic [SYM_W-1:0] SYM_ONE = 2'h1;
  localparam logic [SYM_W-1:0] SYM_OPEN = 2'h2;
  localparam logic [SYM_W-1:0] SYM_GAP = 2'h3;
  localparam logic [3:0] PAT_ZERO = 4'h8;
  localparam logic [3:0] PAT_ONE = 4'he;
  localparam logic [3:0] PAT_OPEN = 4'hc;
  localparam logic [3:0] PAT_GAP = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WORD = 3'b010,
    ST_GAP = 3'b100
  } rem_state_e;
endpackage : rem_pkg

//--- rem_encoder.sv
// Remote encoder: symbol FIFO and the top-level encoder with its register port.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module rem_fifo #(
  parameter int W = 2,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } rem_fifo_s;

  rem_fifo_s q_r;
  rem_fifo_s q_nxt;
  logic push;
  logic pop;

  assign in_ready = (q_r.cnt != FULL);
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[q_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = (q_r.wp == LAST) ? '0 : q_r.wp + 1'b1;
    end
    if (pop) begin
      q_nxt.rp = (q_r.rp == LAST) ? '0 : q_r.rp + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : rem_fifo

module rem_encoder (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic transmit_trigger,
  input wire logic [rem_pkg::ADDR_W-1:0] address_inputs,
  input wire logic [rem_pkg::DATA_W-1:0] data_inputs,
  input wire logic data_bit_type_strap,
  input wire logic address_bit_type_strap_low,
  input wire logic address_bit_type_strap_high,
  input wire logic [rem_pkg::ADDR_W-1:0] address_connected,
  input wire logic [rem_pkg::DATA_W-1:0] data_connected,
  input wire logic [2:0] strap_connected,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mod_out,
  output logic tx_active
);
  localparam int PIN_W = 2 * (rem_pkg::ADDR_W + rem_pkg::DATA_W) + 7;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    rem_pkg::rem_state_e state;
    logic [1:0] word_idx;
    logic [4:0] bit_idx;
    logic [2:0] gap_idx;
    logic [rem_pkg::ADDR_W-1:0] smp_addr;
    logic [rem_pkg::DATA_W-1:0] smp_data;
    logic [2:0] smp_strap;
    logic [15:0] chip_len;
    logic [7:0] cyc_cnt;
    logic ser_busy;
    logic [3:0] ser_pat;
    logic [1:0] chip_idx;
    logic [15:0] chip_cnt;
    logic [15:0] ser_len;
    logic tx_out;
    logic [31:0] rdata;
  } rem_enc_s;

  rem_enc_s q_r;
  rem_enc_s q_nxt;

  // Pins resolved to their logic level, unconnected ones by their internal pull.
  logic trig;
  logic [rem_pkg::ADDR_W-1:0] addr_lvl;
  logic [rem_pkg::DATA_W-1:0] data_lvl;
  logic dcfg;
  logic acfg_lo;
  logic acfg_hi;
  logic [rem_pkg::ADDR_W-1:0] s_aconn;
  logic [rem_pkg::DATA_W-1:0] s_dconn;
  logic [2:0] s_sconn;
  logic [rem_pkg::ADDR_W-1:0] s_addr;
  logic [rem_pkg::DATA_W-1:0] s_data;

  logic sym_valid;
  logic sym_ready;
  logic [rem_pkg::SYM_W-1:0] sym_in;
  logic fifo_valid;
  logic fifo_pop;
  logic [rem_pkg::SYM_W-1:0] fifo_sym;
  logic chip_end;
  logic sym_end;

  // Maps one input level to a symbol given which level is sent as open.
  function automatic logic [rem_pkg::SYM_W-1:0] lvl_sym(input logic lvl, input logic hi_open,
                                                        input logic lo_open);
    if (lvl) begin
      lvl_sym = hi_open ? rem_pkg::SYM_OPEN : rem_pkg::SYM_ONE;
    end else begin
      lvl_sym = lo_open ? rem_pkg::SYM_OPEN : rem_pkg::SYM_ZERO;
    end
  endfunction : lvl_sym

  function automatic logic [3:0] sym_pat(input logic [rem_pkg::SYM_W-1:0] s);
    case (s)
      rem_pkg::SYM_ZERO: sym_pat = rem_pkg::PAT_ZERO;
      rem_pkg::SYM_ONE: sym_pat = rem_pkg::PAT_ONE;
      rem_pkg::SYM_OPEN: sym_pat = rem_pkg::PAT_OPEN;
      default: sym_pat = rem_pkg::PAT_GAP;
    endcase
  endfunction : sym_pat

  assign {s_sconn, s_dconn, s_aconn, acfg_hi, acfg_lo, dcfg, trig, s_data, s_addr} = q_r.sync2;
  // Internal pulls: address up, data down, straps as their defaults.
  assign addr_lvl = s_addr | ~s_aconn;
  assign data_lvl = s_data & s_dconn;

  rem_fifo #(
    .W(rem_pkg::SYM_W),
    .DEPTH(rem_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(sym_valid),
    .in_ready(sym_ready),
    .in_data(sym_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_sym)
  );

  // Word symbol in transit: address bits A0 upward, then data bits D0 upward.
  always_comb begin
    sym_valid = 1'b0;
    sym_in = rem_pkg::SYM_GAP;
    case (q_r.state)
      rem_pkg::ST_WORD: begin
        sym_valid = 1'b1;
        if (q_r.bit_idx < 5'(rem_pkg::ADDR_W)) begin
          // Straps 01 send low as open, 10 send high as open.
          sym_in = lvl_sym(q_r.smp_addr[q_r.bit_idx[3:0]],
                           q_r.smp_strap[2] && !q_r.smp_strap[1],
                           !q_r.smp_strap[2] && q_r.smp_strap[1]);
        end else begin
          // A low data strap turns data lows into open bits.
          sym_in = lvl_sym(q_r.smp_data[3'(q_r.bit_idx - 5'(rem_pkg::ADDR_W))],
                           1'b0, !q_r.smp_strap[0]);
        end
      end
      rem_pkg::ST_GAP: begin
        sym_valid = 1'b1;
      end
      default: begin
        sym_valid = 1'b0;
      end
    endcase
  end

  assign chip_end = q_r.ser_busy && (q_r.chip_cnt == q_r.ser_len - 16'h0001);
  assign sym_end = chip_end && (q_r.chip_idx == 2'h3);
  // Popping on the last chip keeps symbols back to back with no idle gap.
  assign fifo_pop = fifo_valid && (!q_r.ser_busy || sym_end);

  always_comb begin
    q_nxt = q_r;
    q_nxt.sync1 = {strap_connected, data_connected, address_connected,
                   address_bit_type_strap_high, address_bit_type_strap_low,
                   data_bit_type_strap, transmit_trigger, data_inputs, address_inputs};
    q_nxt.sync2 = q_r.sync1;

    // Symbol builder: the sampled values are frozen for one whole cycle.
    case (q_r.state)
      rem_pkg::ST_IDLE: begin
        if (trig) begin
          q_nxt.state = rem_pkg::ST_WORD;
          q_nxt.smp_addr = addr_lvl;
          q_nxt.smp_data = data_lvl;
          // Unconnected straps fall to data low, address low low, address high high.
          q_nxt.smp_strap = {acfg_hi | ~s_sconn[2], acfg_lo & s_sconn[1],
                             dcfg & s_sconn[0]};
          q_nxt.word_idx = 2'h0;
          q_nxt.bit_idx = 5'h00;
        end
      end
      rem_pkg::ST_WORD: begin
        if (sym_ready) begin
          if (q_r.bit_idx == 5'(rem_pkg::WORD_BITS - 1)) begin
            q_nxt.state = rem_pkg::ST_GAP;
            q_nxt.gap_idx = 3'h0;
          end else begin
            q_nxt.bit_idx = q_r.bit_idx + 5'h01;
          end
        end
      end
      rem_pkg::ST_GAP: begin
        if (sym_ready) begin
          if (q_r.gap_idx != 3'(rem_pkg::GAP_SYMS - 1)) begin
            q_nxt.gap_idx = q_r.gap_idx + 3'h1;
          end else if (q_r.word_idx != 2'(rem_pkg::WORDS_PER_CYCLE - 1)) begin
            q_nxt.state = rem_pkg::ST_WORD;
            q_nxt.word_idx = q_r.word_idx + 2'h1;
            q_nxt.bit_idx = 5'h00;
          end else begin
            q_nxt.cyc_cnt = q_r.cyc_cnt + 8'h01;
            // Within a running cycle the trigger is only looked at here, so a cycle is never cut short.
            q_nxt.state = rem_pkg::ST_IDLE;
            if (trig) begin
              q_nxt.state = rem_pkg::ST_WORD;
              q_nxt.smp_addr = addr_lvl;
              q_nxt.smp_data = data_lvl;
              q_nxt.smp_strap = {acfg_hi | ~s_sconn[2], acfg_lo & s_sconn[1],
                                 dcfg & s_sconn[0]};
              q_nxt.word_idx = 2'h0;
              q_nxt.bit_idx = 5'h00;
            end
          end
        end
      end
      default: begin
        q_nxt.state = rem_pkg::ST_IDLE;
      end
    endcase

    // Line coder: four chips a symbol, each chip ser_len clocks long.
    if (fifo_pop) begin
      q_nxt.ser_busy = 1'b1;
      q_nxt.ser_pat = sym_pat(fifo_sym);
      q_nxt.ser_len = q_r.chip_len;
      q_nxt.chip_idx = 2'h0;
      q_nxt.chip_cnt = 16'h0000;
      q_nxt.tx_out = sym_pat(fifo_sym) >> 3 != 4'h0;
    end else if (sym_end) begin
      q_nxt.ser_busy = 1'b0;
      q_nxt.tx_out = 1'b0;
    end else if (chip_end) begin
      q_nxt.chip_idx = q_r.chip_idx + 2'h1;
      q_nxt.chip_cnt = 16'h0000;
      q_nxt.tx_out = q_r.ser_pat[2'h2 - q_r.chip_idx];
    end else if (q_r.ser_busy) begin
      q_nxt.chip_cnt = q_r.chip_cnt + 16'h0001;
    end

    // Register port. The chip length is clamped so two full cycles fit the lag bound.
    if (reg_wr && reg_addr == rem_pkg::REG_CTRL) begin
      if (reg_wdata[15:0] == 16'h0000) begin
        q_nxt.chip_len = 16'h0001;
      end else if (reg_wdata[15:0] > rem_pkg::CHIP_MAX_16) begin
        q_nxt.chip_len = rem_pkg::CHIP_MAX_16;
      end else begin
        q_nxt.chip_len = reg_wdata[15:0];
      end
    end
    q_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        rem_pkg::REG_CTRL: begin
          q_nxt.rdata = {16'h0000, q_r.chip_len};
        end
        rem_pkg::REG_STATUS: begin
          q_nxt.rdata[rem_pkg::ST_BUSY_BIT] = tx_active;
          q_nxt.rdata[rem_pkg::ST_TRIG_BIT] = trig;
          q_nxt.rdata[rem_pkg::ST_WORD_LSB +: 2] = q_r.word_idx;
          q_nxt.rdata[rem_pkg::ST_CNT_LSB +: 8] = q_r.cyc_cnt;
        end
        rem_pkg::REG_SAMPLE: begin
          q_nxt.rdata[rem_pkg::ADDR_W-1:0] = q_r.smp_addr;
          q_nxt.rdata[rem_pkg::SMP_DATA_LSB +: rem_pkg::DATA_W] = q_r.smp_data;
          q_nxt.rdata[rem_pkg::SMP_STRAP_LSB +: 3] = q_r.smp_strap;
        end
        default: begin
          q_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.state <= rem_pkg::ST_IDLE;
      q_r.chip_len <= rem_pkg::CHIP_RST;
      q_r.ser_len <= rem_pkg::CHIP_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign mod_out = q_r.tx_out;
  assign tx_active = (q_r.state != rem_pkg::ST_IDLE) || fifo_valid || q_r.ser_busy;
endmodule : rem_encoder

//--- rem_checker.sv
// Port assertions for the remote encoder.
`timescale 1ns/1ps
module rem_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic transmit_trigger,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mod_out,
  input wire logic tx_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not cleared");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  len_floor_a: assert property (reg_wr && reg_addr == rem_pkg::REG_CTRL &&
    reg_wdata[15:0] == 16'h0 ##2 reg_rd && reg_addr == rem_pkg::REG_CTRL |=> reg_rdata == 32'h1)
    else $error("chip length floor");
  len_ceiling_a: assert property (reg_wr && reg_addr == rem_pkg::REG_CTRL &&
    reg_wdata[15:0] == 16'hffff ##2 reg_rd && reg_addr == rem_pkg::REG_CTRL
    |=> reg_rdata == 32'hb18)
    else $error("chip length ceiling");
  status_busy_a: assert property (reg_rd && reg_addr == rem_pkg::REG_STATUS
    |=> reg_rdata[rem_pkg::ST_BUSY_BIT] == $past(tx_active))
    else $error("status busy bit wrong");
  start_a: assert property ($rose(transmit_trigger) && !tx_active
    ##1 transmit_trigger[*2] |-> ##[1:6] tx_active)
    else $error("trigger did not start sending");
  keep_going_a: assert property (transmit_trigger[*4] ##1 tx_active |=> tx_active)
    else $error("sending stopped with trigger high");
  line_quiet_a: assert property (!tx_active |-> !mod_out)
    else $error("modulation while idle");
endmodule : rem_checker

bind rem_encoder rem_checker u_rem_checker (
  .core_clk(core_clk),
  .rstn(rstn),
  .transmit_trigger(transmit_trigger),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .mod_out(mod_out),
  .tx_active(tx_active)
);

//--- rem_decoder_model.sv
// Behavioural remote decoder listening to the modulating bit stream.
`timescale 1ns/1ps
module rem_decoder_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic mod_out,
  input wire logic [19:0] local_syms,
  output logic [35:0] word_syms,
  output logic [15:0] word_cnt,
  output logic [7:0] dec_data,
  output logic dec_hit
);
  // Assumes one clock per chip, so the bench must program that length first.
  int ph;
  int ones;
  int idle;
  int nsym;
  logic [35:0] acc;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {ph, ones, idle, nsym} = '0;
      acc = '0;
      word_syms <= '0;
      word_cnt <= '0;
      dec_data <= '0;
      dec_hit <= 1'b0;
    end else if (ph == 0) begin
      if (mod_out) begin
        ph = 1;
        ones = 1;
        idle = 0;
      end else if (idle < 8) begin
        idle++;
      end else begin
        // A long silence realigns the word, so a lost chip cannot shift every later word.
        nsym = 0;
      end
    end else begin
      ones += int'(mod_out);
      ph++;
      if (ph == 4) begin
        ph = 0;
        acc[2*nsym +: 2] = ones == 3 ? 2'h1 : (ones == 2 ? 2'h2 : 2'h0);
        nsym++;
        if (nsym == 18) begin
          nsym = 0;
          word_syms <= acc;
          word_cnt <= word_cnt + 16'h1;
          dec_hit <= acc[19:0] == local_syms;
          if (acc[19:0] == local_syms) begin
            for (int i = 0; i < 8; i++)
              dec_data[i] <= acc[20+2*i +: 2] == 2'h1;
          end
        end
      end
    end
  end
endmodule : rem_decoder_model

//--- tb.sv
// Self-checking testbench for the remote encoder.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic trg = 1'b0;
  logic [9:0] addr = 10'h2b5;
  logic [7:0] data = 8'h3c;
  logic dcfg = 1'b0;
  logic alo = 1'b0;
  logic ahi = 1'b0;
  logic [9:0] acon = 10'h3ff;
  logic [7:0] dcon = 8'hff;
  logic [2:0] scon = 3'h7;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic mod_out;
  logic tx_active;
  logic [19:0] lsyms = 20'h0;
  logic [35:0] syms;
  logic [15:0] wcnt;
  logic [7:0] ddata;
  logic dhit;
  int checks = 0;
  int bad_count = 0;
  always #50 core_clk = ~core_clk;
  rem_encoder u_rem_encoder (
    .core_clk(core_clk),
    .rstn(rstn),
    .transmit_trigger(trg),
    .address_inputs(addr),
    .data_inputs(data),
    .data_bit_type_strap(dcfg),
    .address_bit_type_strap_low(alo),
    .address_bit_type_strap_high(ahi),
    .address_connected(acon),
    .data_connected(dcon),
    .strap_connected(scon),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .mod_out(mod_out),
    .tx_active(tx_active)
  );
  rem_decoder_model u_rem_decoder_model (
    .core_clk(core_clk),
    .rstn(rstn),
    .mod_out(mod_out),
    .local_syms(lsyms),
    .word_syms(syms),
    .word_cnt(wcnt),
    .dec_data(ddata),
    .dec_hit(dhit)
  );
  function automatic logic [35:0] expw(input logic [9:0] a, input logic [7:0] d,
                                       input logic [2:0] s);
    logic [35:0] w;
    w = '0;
    for (int i = 0; i < 10; i++)
      w[2*i +: 2] = a[i] ? (s[2:1] == 2'b10 ? 2'h2 : 2'h1) : (s[2:1] == 2'b01 ? 2'h2 : 2'h0);
    for (int i = 0; i < 8; i++)
      w[20+2*i +: 2] = d[i] ? 2'h1 : (s[0] ? 2'h0 : 2'h2);
    return w;
  endfunction : expw
  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus_rd
  // Waits for the line to go idle, or for the word count to reach n when n is not zero.
  task automatic wait_for(input logic [15:0] n);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      #1 k++;
    end while ((n == 0 ? tx_active !== 1'b0 : wcnt < n) && k < 3000);
    if (k >= 3000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_for
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(rem_pkg::REG_CTRL, d);
    chk(36'(d), 36'h3e8, "len reset");
    bus_wr(rem_pkg::REG_CTRL, 32'h0);
    bus_rd(rem_pkg::REG_CTRL, d);
    chk(36'(d), 36'h1, "len floor");
    bus_wr(rem_pkg::REG_CTRL, 32'hffff);
    bus_rd(rem_pkg::REG_CTRL, d);
    chk(36'(d), 36'hb18, "len ceiling");
    bus_rd(8'h0c, d);
    chk(36'(d), 36'h0, "unmapped");
    bus_wr(rem_pkg::REG_CTRL, 32'h1);
  endtask : t_regs
  task automatic burst(input logic [35:0] e, input logic [7:0] de);
    logic [15:0] w0;
    w0 = wcnt;
    @(posedge core_clk);
    lsyms <= e[19:0];
    trg <= 1'b1;
    repeat (8) @(posedge core_clk);
    trg <= 1'b0;
    #1 chk(36'(tx_active), 36'h1, "active");
    wait_for(16'h0);
    chk(36'(wcnt - w0), 36'h3, "words");
    chk(syms, e, "symbols");
    chk(36'({dhit, ddata}), 36'({1'b1, de}), "decoded");
  endtask : burst
  task automatic t_straps();
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      {ahi, alo, dcfg} <= 3'(s);
      burst(expw(addr, data, 3'(s)), data);
    end
  endtask : t_straps
  task automatic t_pulls();
    logic [31:0] d;
    @(posedge core_clk);
    {scon, dcon, acon, addr} <= {3'h0, 8'h00, 10'h3e0, 10'h000};
    burst(expw(10'h01f, 8'h00, 3'h4), 8'h00);
    bus_rd(rem_pkg::REG_SAMPLE, d);
    chk(36'(d[20:0]), 36'h10001f, "sampled");
    @(posedge core_clk);
    {scon, dcon, acon, addr} <= {3'h7, 8'hff, 10'h3ff, 10'h2b5};
  endtask : t_pulls
  task automatic t_hold();
    logic [31:0] d;
    logic [35:0] e;
    @(posedge core_clk);
    {ahi, alo, dcfg} <= 3'h1;
    trg <= 1'b1;
    repeat (100) @(posedge core_clk);
    data <= 8'hc3;
    e = expw(10'h2b5, 8'hc3, 3'h1);
    lsyms <= e[19:0];
    wait_for(wcnt + 16'h6);
    chk(syms, e, "refresh");
    bus_rd(rem_pkg::REG_STATUS, d);
    chk(36'(d[1:0]), 36'h3, "status");
    @(posedge core_clk);
    trg <= 1'b0;
    wait_for(16'h0);
    chk(36'(wcnt % 3), 36'h0, "whole cycles");
    chk(36'(mod_out), 36'h0, "quiet");
  endtask : t_hold
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_straps();
    t_pulls();
    t_hold();
    tally_and_finish();
  end
endmodule : tb
